// *** ntpt_defines.svh ***
`ifndef NTPT_DEFINES_SVH
`define NTPT_DEFINES_SVH

// Count of tristate bidirectional pins: both address/data buses,
// byte enables, parities, primary request and secondary grants.
`define NTPT_TS_W    79
// Count of sustained-tristate control pins on both buses
`define NTPT_STS_W   14
// Count of input-only pins that feed the chain (clocks excluded)
`define NTPT_CHAIN_W 13

// Chain positions, clockwise from the secondary arbiter enable pin
`define NTPT_POS_S_ARB_EN  0
`define NTPT_POS_S_VIO     1
`define NTPT_POS_FLOAT_N   2
`define NTPT_POS_P_RST_N   3
`define NTPT_POS_P_VIO     4
`define NTPT_POS_P_GNT_N   5
`define NTPT_POS_P_IDSEL   6
`define NTPT_POS_BPCC      7
`define NTPT_POS_S_SERR_N  8
`define NTPT_POS_S_REQ0_N  9
`define NTPT_POS_S_REQ1_N  10
`define NTPT_POS_S_REQ2_N  11
`define NTPT_POS_S_REQ3_N  12

// Reset values of the pad output stages
`define NTPT_RST_LOW  1'h0
`define NTPT_RST_PARK 1'h0

`endif

// *** ntpt_nand_tree_pin_test.sv ***
`timescale 1ns/1ps
`include "ntpt_defines.svh"

module ntpt_nand_tree_pin_test
  import ntpt_pkg::*;
(
  // Clock and synchronous reset
  input  wire logic      core_clk,
  input  wire logic      reset,
  // Diagnostic float control, active low
  input  wire logic      diag_float_n,
  // Input-only pins observed by the chain
  input  wire logic      s_arb_en_n,
  input  wire logic      s_vio,
  input  wire logic      p_rst_n,
  input  wire logic      p_vio,
  input  wire logic      p_gnt_n,
  input  wire logic      p_idsel,
  input  wire logic      bpcc,
  input  wire logic      s_serr_n,
  input  wire logic [3:0] s_req_n,
  // Core requests for tristate bidirectional pins
  input  wire ntpt_ts_t  ts_core_out,
  input  wire ntpt_ts_t  ts_core_oe,
  // Core requests for the open-drain error pin
  input  wire logic      od_core_low,
  // Core requests: sustained-tristate pin asserted (driven low)
  input  wire ntpt_sts_t sts_core_low,
  // Tristate bidirectional pads
  output ntpt_ts_t       ts_pad_out,
  output ntpt_ts_t       ts_pad_oe,
  // Open-drain pad
  output logic           od_pad_out,
  output logic           od_pad_oe,
  // Sustained-tristate pads
  output ntpt_sts_t      sts_pad_out,
  output ntpt_sts_t      sts_pad_oe,
  // Dedicated chain test output
  output logic           chain_out
);

  ntpt_chain_t chain_in;
  ntpt_chain_t stage;
  ntpt_ts_t    ts_out_r;
  ntpt_ts_t    ts_oe_r;
  logic        od_low_r;
  ntpt_sts_t   sts_low_r;
  ntpt_sts_t   sts_park_r;

  // Chain taps in clockwise pin order; clocks are deliberately left out
  // so a toggling clock cannot mask a stuck input pin.
  always_comb
  begin
    chain_in                      = '0;
    chain_in[`NTPT_POS_S_ARB_EN]  = s_arb_en_n;
    chain_in[`NTPT_POS_S_VIO]     = s_vio;
    chain_in[`NTPT_POS_FLOAT_N]   = diag_float_n;
    chain_in[`NTPT_POS_P_RST_N]   = p_rst_n;
    chain_in[`NTPT_POS_P_VIO]     = p_vio;
    chain_in[`NTPT_POS_P_GNT_N]   = p_gnt_n;
    chain_in[`NTPT_POS_P_IDSEL]   = p_idsel;
    chain_in[`NTPT_POS_BPCC]      = bpcc;
    chain_in[`NTPT_POS_S_SERR_N]  = s_serr_n;
    chain_in[`NTPT_POS_S_REQ0_N]  = s_req_n[0];
    chain_in[`NTPT_POS_S_REQ1_N]  = s_req_n[1];
    chain_in[`NTPT_POS_S_REQ2_N]  = s_req_n[2];
    chain_in[`NTPT_POS_S_REQ3_N]  = s_req_n[3];
  end

  // First stage sees a constant high partner so it acts as an inverter
  assign stage[0] = ~chain_in[0];

  // Remaining stages ripple through the chain with no flops in the path
  for (genvar k = 1; k < `NTPT_CHAIN_W; k++)
  begin : g_chain
    assign stage[k] = ~(stage[k-1] & chain_in[k]);
  end

  // Unclocked by design: the tester must see pins without a clock running
  assign chain_out = stage[`NTPT_CHAIN_W-1];

  // Bidirectional pad values, registered from the core
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ts_out_r <= '0;
      ts_oe_r  <= '0;
    end
    else
    begin
      ts_out_r <= ts_core_out;
      ts_oe_r  <= ts_core_oe;
    end
  end

  // Open-drain request, registered from the core
  always_ff @(posedge core_clk)
  begin
    if (reset)
      od_low_r <= `NTPT_RST_LOW;
    else
      od_low_r <= od_core_low;
  end

  // Sustained-tristate release: one park-high cycle after deassertion
  // keeps the shared line from drifting slowly up through the pull-up.
  for (genvar j = 0; j < `NTPT_STS_W; j++)
  begin : g_sts
    always_ff @(posedge core_clk)
    begin
      if (reset)
      begin
        sts_low_r[j]  <= `NTPT_RST_LOW;
        sts_park_r[j] <= `NTPT_RST_PARK;
      end
      else
      begin
        sts_low_r[j]  <= sts_core_low[j];
        sts_park_r[j] <= sts_low_r[j] & ~sts_core_low[j];
      end
    end
  end

  // Float gating is unclocked so the pins let go at once, even in reset
  assign ts_pad_out  = ts_out_r;
  assign ts_pad_oe   = ts_oe_r & {`NTPT_TS_W{diag_float_n}};
  assign od_pad_out  = 1'h0;
  assign od_pad_oe   = od_low_r & diag_float_n;
  assign sts_pad_out = ~sts_low_r; // Park cycle drives high
  assign sts_pad_oe  = (sts_low_r | sts_park_r)
                       & {`NTPT_STS_W{diag_float_n}};

  // Steps of one sustained-tristate release on pin 0
  sequence s_sts0_release;
    sts_low_r[0] && !sts_core_low[0];
  endsequence

  sequence s_sts0_park_then_float;
    (sts_pad_oe[0] && sts_pad_out[0]) ##1 (!sts_pad_oe[0]);
  endsequence

  a_sts_release_park: assert property (
    @(posedge core_clk) disable iff (reset)
    s_sts0_release |=> sts_park_r[0] && sts_pad_out[0])
    else $error("release did not start a park cycle");

  a_sts_park_float: assert property (
    @(posedge core_clk) disable iff (reset)
    (s_sts0_release and (diag_float_n && !sts_core_low[0]))
      ##1 (diag_float_n && !sts_core_low[0])
      |-> s_sts0_park_then_float)
    else $error("sustained pin did not park high then float");

  a_sts_park_once: assert property (
    @(posedge core_clk) disable iff (reset)
    sts_park_r[0] |=> !sts_park_r[0])
    else $error("park high lasted more than one cycle");

  a_float_bidir_off: assert property (
    @(posedge core_clk)
    !diag_float_n |-> (ts_pad_oe == '0) && !od_pad_oe)
    else $error("bidirectional pin driven while floated");

  a_float_sts_off: assert property (
    @(posedge core_clk)
    !diag_float_n |-> (sts_pad_oe == '0))
    else $error("sustained pin driven while floated");

  a_drive_follows_core: assert property (
    @(posedge core_clk) disable iff (reset)
    diag_float_n && $past(ts_core_oe[0]) && !$past(reset)
      |-> ts_pad_oe[0] && (ts_pad_out[0] == $past(ts_core_out[0])))
    else $error("bidirectional pin ignored core request");

  a_chain_head: assert property (
    @(posedge core_clk)
    stage[0] == ~s_arb_en_n)
    else $error("chain does not start at arbiter enable");

  a_chain_taps: assert property (
    @(posedge core_clk)
    chain_in == {s_req_n[3], s_req_n[2], s_req_n[1], s_req_n[0],
                 s_serr_n, bpcc, p_idsel, p_gnt_n, p_vio, p_rst_n,
                 diag_float_n, s_vio, s_arb_en_n})
    else $error("chain taps out of order");

  a_chain_tail: assert property (
    @(posedge core_clk)
    chain_out == ~(stage[`NTPT_CHAIN_W-2] & s_req_n[3]))
    else $error("chain output not last stage");

  a_chain_low_all_high: assert property (
    @(posedge core_clk)
    (&chain_in) |-> (chain_out == 1'b0))
    else $error("chain output wrong with all pins high");

  // A lone low pin at the head must flip the whole chain
  a_chain_head_low: assert property (
    @(posedge core_clk)
    (chain_in == 13'h1FFE) |-> (chain_out == 1'b1))
    else $error("head pin low did not reach chain output");

  // The float pin is itself a tap, so it must also flip the chain
  a_float_tap_low: assert property (
    @(posedge core_clk)
    (chain_in == 13'h1FFB) |-> (chain_out == 1'b1))
    else $error("float tap low did not reach chain output");

  // An asserted sustained pin is actively driven low
  a_sts_low_drive: assert property (
    @(posedge core_clk) disable iff (reset)
    (diag_float_n && sts_low_r[0]) |-> (sts_pad_oe[0] && !sts_pad_out[0]))
    else $error("asserted sustained pin not driven low");

  // Reasserting during the park cycle goes straight back to low
  a_sts_reassert: assert property (
    @(posedge core_clk) disable iff (reset)
    (sts_park_r[0] && sts_core_low[0]) |=> (sts_low_r[0] && !sts_pad_out[0]))
    else $error("reassert during park not honoured");

endmodule : ntpt_nand_tree_pin_test

// *** ntpt_pkg.sv ***
`include "ntpt_defines.svh"

package ntpt_pkg;

  typedef logic [`NTPT_TS_W-1:0]    ntpt_ts_t;
  typedef logic [`NTPT_STS_W-1:0]   ntpt_sts_t;
  typedef logic [`NTPT_CHAIN_W-1:0] ntpt_chain_t;

endpackage : ntpt_pkg

// *** ntpt_tester.sv ***
`timescale 1ns/1ps
// Board tester model: moves the pins on the falling edge only
module ntpt_tester
  import ntpt_pkg::*;
(
  // Clock and request from the bench
  input  wire logic        core_clk,
  input  wire logic        chain_on,
  input  wire ntpt_chain_t pat,
  // Input-only pins in chain order
  output ntpt_chain_t      pins
);
  ntpt_chain_t pins_r = '1;

  // Float held low while the chain is in use
  always @(negedge core_clk)
  begin
    pins_r <= {pat[12:3], pat[2] & ~chain_on, pat[1:0]};
  end
  assign pins = pins_r;
endmodule : ntpt_tester

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
  import ntpt_pkg::*;
  logic        core_clk = 1'h0;
  logic        reset = 1'h1;
  logic        chain_on = 1'h0;
  logic        od_core_low = 1'h0;
  logic        od_pad_out, od_pad_oe, chain_out;
  ntpt_chain_t pat = '1;
  ntpt_chain_t pins;
  ntpt_ts_t    ts_core_out = '0;
  ntpt_ts_t    ts_core_oe = '0;
  ntpt_ts_t    ts_pad_out, ts_pad_oe;
  ntpt_sts_t   sts_core_low = '0;
  ntpt_sts_t   sts_pad_out, sts_pad_oe;
  int          num_errors = 0;
  int          compares = 0;
  int          cycles = 0;

  always #12.5 core_clk = ~core_clk;

  ntpt_tester tester_u (.core_clk(core_clk), .chain_on(chain_on),
    .pat(pat), .pins(pins));

  ntpt_nand_tree_pin_test dut_u (.core_clk(core_clk), .reset(reset),
    .diag_float_n(pins[2]), .s_arb_en_n(pins[0]), .s_vio(pins[1]),
    .p_rst_n(pins[3]), .p_vio(pins[4]), .p_gnt_n(pins[5]),
    .p_idsel(pins[6]), .bpcc(pins[7]), .s_serr_n(pins[8]),
    .s_req_n(pins[12:9]), .ts_core_out(ts_core_out),
    .ts_core_oe(ts_core_oe), .od_core_low(od_core_low),
    .sts_core_low(sts_core_low), .ts_pad_out(ts_pad_out),
    .ts_pad_oe(ts_pad_oe), .od_pad_out(od_pad_out),
    .od_pad_oe(od_pad_oe), .sts_pad_out(sts_pad_out),
    .sts_pad_oe(sts_pad_oe), .chain_out(chain_out));

  task automatic end_sim;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  // Hang guard: the whole run needs well under a hundred cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      num_errors++;
      end_sim();
    end
  end

  task automatic check(input logic [78:0] seen, exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask : check

  function automatic logic chain_exp(input ntpt_chain_t p);
    logic s;
    s = ~p[0];
    for (int k = 1; k < 13; k++)
      s = ~(s & p[k]);
    return s;
  endfunction : chain_exp

  // Walking zero, float free then held; core pads toggle to show no leak
  task automatic chain_test;
    for (int m = 0; m < 2; m++)
      for (int i = 0; i < 14; i++)
      begin
        @(negedge core_clk);
        chain_on = m[0];
        pat = '1;
        if (i < 13)
          pat[i] = 1'h0;
        ts_core_oe = {79{i[0]}};
        sts_core_low = {14{i[1]}};
        @(negedge core_clk);
        #1;
        check(chain_out, chain_exp(pins), "chain");
      end
    chain_on = 1'h0;
    pat = '1;
  endtask : chain_test

  // Pads driven, then float low releases every one at once
  task automatic float_test;
    @(negedge core_clk);
    ts_core_oe = '1;
    ts_core_out = 79'h2AAA_AAAA_AAAA_AAAA_AAAA;
    od_core_low = 1'h1;
    sts_core_low = '1;
    @(negedge core_clk);
    check(ts_pad_oe, '1, "ts oe");
    check(ts_pad_out, 79'h2AAA_AAAA_AAAA_AAAA_AAAA, "ts out");
    check(od_pad_oe, 1'h1, "od oe");
    check(od_pad_out, 1'h0, "od out");
    check(sts_pad_oe, 14'h3FFF, "sts oe");
    pat[2] = 1'h0;
    @(negedge core_clk);
    #1;
    check(ts_pad_oe, '0, "float ts");
    check(od_pad_oe, 1'h0, "float od");
    check(sts_pad_oe, '0, "float sts");
    pat = '1;
    @(negedge core_clk);
  endtask : float_test

  // Low, then one park cycle high, then undriven
  task automatic park_test;
    sts_core_low = '1;
    @(negedge core_clk);
    check({sts_pad_oe, sts_pad_out}, {14'h3FFF, 14'h0}, "low");
    sts_core_low = '0;
    @(negedge core_clk);
    check({sts_pad_oe, sts_pad_out}, {28{1'h1}}, "park");
    @(negedge core_clk);
    check(sts_pad_oe, '0, "release");
  endtask : park_test

  initial
  begin
    repeat (2) @(negedge core_clk);
    reset = 1'h0;
    chain_test();
    float_test();
    park_test();
    end_sim();
  end
endmodule : testbench
